// ### common/smc_pkg.sv
/*
  Constants shared by the serial bus configuration block: register
  decode, field positions, reset values, timing counts and the
  encoding of the bit-rate source select.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package smc_pkg;

  // ----------------------------------------------------------------
  // Register decode.
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'hC1;
  localparam logic [3:0] PAGE_BUS0 = 4'h0;
  localparam logic [3:0] PAGE_BUS1 = 4'hF;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // The busy bit is read only, so writes never reach bit 5.
  localparam logic [7:0] CFG_WR_MASK = 8'hDF;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of each configuration register.
  // ----------------------------------------------------------------
  localparam int EN_BIT = 7;
  localparam int INH_BIT = 6;
  localparam int BUSY_BIT = 5;
  localparam int EXT_BIT = 4;
  localparam int TOE_BIT = 3;
  localparam int FTE_BIT = 2;
  localparam int CS_MSB = 1;
  localparam int CS_LSB = 0;

  // ----------------------------------------------------------------
  // Timing counts, in source periods or system clocks.
  // ----------------------------------------------------------------
  localparam logic [3:0] FREE_PERIODS = 4'hA;
  localparam logic [3:0] HOLD_NORMAL = 4'h3;
  localparam logic [3:0] HOLD_EXT = 4'hC;
  localparam logic [3:0] SETUP_EXT = 4'hB;
  // Zero tells the shift engine to take setup from the low time.
  localparam logic [3:0] SETUP_LOW_TIME = 4'h0;

  // Bit-rate source select codes.
  typedef enum logic [1:0] {
    SRC_TMR0 = 2'b00,
    SRC_ALT = 2'b01,
    SRC_TMR2_HI = 2'b10,
    SRC_TMR2_LO = 2'b11
  } smc_src_e;

endpackage : smc_pkg

// ### rtl/smc_sync.sv
/*
  Two-stage synchroniser for levels that arrive from outside the
  system clock domain.
  Assumes the inputs are slow levels; it does not catch pulses.
*/
`timescale 1ns/1ns
`default_nettype none

module smc_sync #(
  parameter int WIDTH = 2
) (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Raw levels and their synchronised copy.
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } smc_sync_s;

  smc_sync_s st_q;
  smc_sync_s st_d;

  // The first stage feeds only the second stage.
  always_comb begin
    st_d.meta = d_i;
    st_d.stable = st_q.meta;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.stable;

endmodule : smc_sync

`default_nettype wire

// ### rtl/smc_monitor.sv
/*
  Line monitor for one bus instance: synchronises the clock and data
  lines, finds START and STOP, keeps the busy flag and the bus-free
  timeout count.
  Assumes rate_tick_i is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module smc_monitor import smc_pkg::*; (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Configuration.
  input wire logic enable_i,
  input wire logic idle_timeout_en_i,
  input wire logic rate_tick_i,
  // Bus lines, asynchronous.
  input wire logic clock_line_i,
  input wire logic data_line_i,
  // Status.
  output logic busy_o,
  output logic clock_high_o
);

  typedef struct packed {
    logic scl_p;
    logic sda_p;
    logic busy;
    logic [3:0] idle;
  } smc_mon_s;

  smc_mon_s st_q;
  smc_mon_s st_d;
  logic [1:0] line_s;
  logic start;
  logic stop;
  logic both_high;
  logic free;

  smc_sync #(.WIDTH(2)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({clock_line_i, data_line_i}),
    .q_o(line_s)
  );

  // Edges are judged on synchronised copies only.
  assign both_high = line_s[1] & line_s[0];
  assign start = st_q.scl_p & line_s[1] & st_q.sda_p & ~line_s[0];
  assign stop = st_q.scl_p & line_s[1] & ~st_q.sda_p & line_s[0];
  // The eleventh period with both lines high ends the wait.
  assign free = idle_timeout_en_i & both_high & rate_tick_i & (st_q.idle == FREE_PERIODS);

  // Next state: busy flag and idle period count.
  always_comb begin
    st_d = st_q;
    st_d.scl_p = line_s[1];
    st_d.sda_p = line_s[0];
    if (!enable_i || !both_high || !idle_timeout_en_i) begin
      st_d.idle = '0;
    end else if (rate_tick_i && st_q.idle <= FREE_PERIODS) begin
      st_d.idle = st_q.idle + 4'h1;
    end
    if (!enable_i) begin
      st_d.busy = 1'b0;
    end else if (start) begin
      st_d.busy = 1'b1;
    end else if (stop || free) begin
      st_d.busy = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign busy_o = st_q.busy;
  assign clock_high_o = line_s[1];

  // A START while enabled marks the bus busy.
  start_sets_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && enable_i && start) |=> busy_o)
    else $error("busy not set by start");

  // A STOP releases the bus.
  stop_clears_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && stop) |=> !busy_o)
    else $error("busy not cleared by stop");

  // Idle lines for more than ten periods release the bus.
  idle_free_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && enable_i && idle_timeout_en_i && both_high && rate_tick_i
     && st_q.idle == FREE_PERIODS) |=> !busy_o)
    else $error("busy not cleared by free timeout");

endmodule : smc_monitor

`default_nettype wire

// ### rtl/smc_top.sv
/*
  Configuration and status logic for two serial bus instances: two
  configuration registers on the special function register bus, the
  bit-rate source selection, timeout timer reload control, setup and
  hold selection, slave interrupt gating and the busy flags.
  Assumes the timer overflows and engine events are one-cycle pulses
  on clock_i, and that the bus lines arrive asynchronously.
*/
// What this block does
// - Enable bit makes the instance watch its lines; clear means no bus part.
// - Slave inhibit suppresses slave interrupts; master interrupts still pass.
// - Busy set while a transfer runs, cleared by STOP or free timeout.
// - Extension bit chooses normal or extended data setup and hold times.
// - Instance 0 holds timer 3 in reload while its clock line is high.
// - In split mode only the timer high byte is held in reload.
// - Bus free after both lines high more than ten source periods.
// - Source codes pick timer 0, timer 1, timer 2 high, timer 2 low.
// - Instance 1 register at 0xC1 on page F, resets to zero.
// - Instance 0 register at 0xC1 on page 0.
// - Instance 1 uses timer 4 for the low clock timeout.
// - Instance 1 code 01 selects timer 5 instead of timer 1.
`timescale 1ns/1ns
`default_nettype none

module smc_top import smc_pkg::*; (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Special function register port.
  input wire logic [7:0] sfr_addr_i,
  input wire logic [3:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Bus lines, asynchronous.
  input wire logic bus0_clock_line_i,
  input wire logic bus0_data_line_i,
  input wire logic bus1_clock_line_i,
  input wire logic bus1_data_line_i,
  // Timer overflow pulses.
  input wire logic tmr0_ovf_i,
  input wire logic tmr1_ovf_i,
  input wire logic tmr2_hi_ovf_i,
  input wire logic tmr2_lo_ovf_i,
  input wire logic tmr5_ovf_i,
  // Timeout timer split mode.
  input wire logic tmr3_split_i,
  input wire logic tmr4_split_i,
  // Events from the shift engines.
  input wire logic bus0_slave_event_i,
  input wire logic bus0_master_event_i,
  input wire logic bus1_slave_event_i,
  input wire logic bus1_master_event_i,
  // Instance 0 controls and status.
  output logic bus0_enable_o,
  output logic bus0_long_setup_hold_o,
  output logic [3:0] bus0_setup_cycles_o,
  output logic [3:0] bus0_hold_cycles_o,
  output logic bus0_bit_tick_o,
  output logic bus0_irq_o,
  output logic bus0_transfer_active_o,
  // Instance 1 controls and status.
  output logic bus1_enable_o,
  output logic bus1_long_setup_hold_o,
  output logic [3:0] bus1_setup_cycles_o,
  output logic [3:0] bus1_hold_cycles_o,
  output logic bus1_bit_tick_o,
  output logic bus1_irq_o,
  output logic bus1_transfer_active_o,
  // Timeout timer reload controls.
  output logic tmr3_hi_reload_o,
  output logic tmr3_lo_reload_o,
  output logic tmr4_hi_reload_o,
  output logic tmr4_lo_reload_o
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] cfg;
    logic [7:0] rdata;
    logic [1:0][3:0] setup;
    logic [1:0][3:0] hold;
    logic [1:0] tick;
    logic [1:0] irq;
    logic [1:0] busy;
    logic [1:0] rl_hi;
    logic [1:0] rl_lo;
  } smc_top_s;

  smc_top_s st_q;
  smc_top_s st_d;

  logic [1:0] clock_line;
  logic [1:0] data_line;
  logic [1:0] alt_ovf;
  logic [1:0] split;
  logic [1:0] slave_ev;
  logic [1:0] master_ev;
  logic [1:0] src_tick;
  logic [1:0] mon_busy;
  logic [1:0] scl_high;
  logic wr_bus0;
  logic wr_bus1;
  logic rd_bus0;
  logic rd_bus1;

  // Gather per-instance pins so both instances share one loop.
  assign clock_line = {bus1_clock_line_i, bus0_clock_line_i};
  assign data_line = {bus1_data_line_i, bus0_data_line_i};
  assign alt_ovf = {tmr5_ovf_i, tmr1_ovf_i};
  assign split = {tmr4_split_i, tmr3_split_i};
  assign slave_ev = {bus1_slave_event_i, bus0_slave_event_i};
  assign master_ev = {bus1_master_event_i, bus0_master_event_i};

  // ----------------------------------------------------------------
  // Register decode.
  // ----------------------------------------------------------------
  // The two registers share one address; the page tells them apart.
  assign wr_bus0 = sfr_wr_i && sfr_addr_i == CFG_ADDR && sfr_page_i == PAGE_BUS0;
  assign wr_bus1 = sfr_wr_i && sfr_addr_i == CFG_ADDR && sfr_page_i == PAGE_BUS1;
  assign rd_bus0 = sfr_rd_i && sfr_addr_i == CFG_ADDR && sfr_page_i == PAGE_BUS0;
  assign rd_bus1 = sfr_rd_i && sfr_addr_i == CFG_ADDR && sfr_page_i == PAGE_BUS1;

  // ----------------------------------------------------------------
  // Per-instance line monitors and source select.
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_inst
    smc_src_e sel;

    assign sel = smc_src_e'(st_q.cfg[g][CS_MSB:CS_LSB]);

    // Overflow that paces this instance's bit rate.
    assign src_tick[g] = (sel == SRC_TMR0) ? tmr0_ovf_i :
                         (sel == SRC_ALT) ? alt_ovf[g] :
                         (sel == SRC_TMR2_HI) ? tmr2_hi_ovf_i : tmr2_lo_ovf_i;

    smc_monitor u_mon (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .enable_i(st_q.cfg[g][EN_BIT]),
      .idle_timeout_en_i(st_q.cfg[g][FTE_BIT]),
      .rate_tick_i(src_tick[g]),
      .clock_line_i(clock_line[g]),
      .data_line_i(data_line[g]),
      .busy_o(mon_busy[g]),
      .clock_high_o(scl_high[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  // Output flops are computed from the registered configuration, so
  // a write takes effect one cycle after it lands.
  always_comb begin
    logic en;
    logic hold_on;
    en = 1'b0;
    hold_on = 1'b0;
    st_d = st_q;
    if (wr_bus0) begin
      st_d.cfg[0] = sfr_wdata_i & CFG_WR_MASK;
    end
    if (wr_bus1) begin
      st_d.cfg[1] = sfr_wdata_i & CFG_WR_MASK;
    end
    // Read data is captured on the strobe and held until the next.
    if (rd_bus0) begin
      st_d.rdata = st_q.cfg[0];
      st_d.rdata[BUSY_BIT] = mon_busy[0];
    end else if (rd_bus1) begin
      st_d.rdata = st_q.cfg[1];
      st_d.rdata[BUSY_BIT] = mon_busy[1];
    end else if (sfr_rd_i) begin
      st_d.rdata = RDATA_RESET;
    end
    for (int i = 0; i < 2; i++) begin
      en = st_q.cfg[i][EN_BIT];
      // Slave events are dropped under inhibit; master ones never.
      st_d.irq[i] = en & (master_ev[i] | (slave_ev[i] & ~st_q.cfg[i][INH_BIT]));
      st_d.tick[i] = en & src_tick[i];
      st_d.busy[i] = mon_busy[i];
      // The timer counts only while the clock line is held low.
      hold_on = en & st_q.cfg[i][TOE_BIT] & scl_high[i];
      st_d.rl_hi[i] = hold_on;
      st_d.rl_lo[i] = hold_on & ~split[i];
      if (st_q.cfg[i][EXT_BIT]) begin
        st_d.setup[i] = SETUP_EXT;
        st_d.hold[i] = HOLD_EXT;
      end else begin
        st_d.setup[i] = SETUP_LOW_TIME;
        st_d.hold[i] = HOLD_NORMAL;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.cfg <= {CFG_RESET, CFG_RESET};
      st_q.rdata <= RDATA_RESET;
      st_q.setup <= {SETUP_LOW_TIME, SETUP_LOW_TIME};
      st_q.hold <= {HOLD_NORMAL, HOLD_NORMAL};
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops.
  // ----------------------------------------------------------------
  assign sfr_rdata_o = st_q.rdata;
  assign bus0_enable_o = st_q.cfg[0][EN_BIT];
  assign bus0_long_setup_hold_o = st_q.cfg[0][EXT_BIT];
  assign bus0_setup_cycles_o = st_q.setup[0];
  assign bus0_hold_cycles_o = st_q.hold[0];
  assign bus0_bit_tick_o = st_q.tick[0];
  assign bus0_irq_o = st_q.irq[0];
  assign bus0_transfer_active_o = st_q.busy[0];
  assign bus1_enable_o = st_q.cfg[1][EN_BIT];
  assign bus1_long_setup_hold_o = st_q.cfg[1][EXT_BIT];
  assign bus1_setup_cycles_o = st_q.setup[1];
  assign bus1_hold_cycles_o = st_q.hold[1];
  assign bus1_bit_tick_o = st_q.tick[1];
  assign bus1_irq_o = st_q.irq[1];
  assign bus1_transfer_active_o = st_q.busy[1];
  assign tmr3_hi_reload_o = st_q.rl_hi[0];
  assign tmr3_lo_reload_o = st_q.rl_lo[0];
  assign tmr4_hi_reload_o = st_q.rl_hi[1];
  assign tmr4_lo_reload_o = st_q.rl_lo[1];

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  page_f_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && wr_bus1) |=> (st_q.cfg[1] == ($past(sfr_wdata_i) & CFG_WR_MASK)))
    else $error("page F write not stored");

  page_0_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && wr_bus0) |=> (st_q.cfg[0] == ($past(sfr_wdata_i) & CFG_WR_MASK))
      && $stable(st_q.cfg[1]))
    else $error("page 0 write not stored or leaked");

  busy_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && rd_bus0) |=> (sfr_rdata_o[BUSY_BIT] == $past(mon_busy[0])))
    else $error("busy bit not read back");

  slave_block_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && st_q.cfg[0][INH_BIT] && bus0_slave_event_i && !bus0_master_event_i)
      |=> !bus0_irq_o)
    else $error("slave interrupt not blocked");

  master_irq_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && st_q.cfg[1][EN_BIT] && bus1_master_event_i) |=> bus1_irq_o)
    else $error("master interrupt lost");

  reload_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && st_q.cfg[0][EN_BIT] && st_q.cfg[0][TOE_BIT] && scl_high[0])
      |=> tmr3_hi_reload_o)
    else $error("timer 3 not held in reload");

  split_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && st_q.cfg[1][EN_BIT] && st_q.cfg[1][TOE_BIT] && scl_high[1]
     && tmr4_split_i) |=> (tmr4_hi_reload_o && !tmr4_lo_reload_o))
    else $error("split mode reload wrong");

  alt_source_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && st_q.cfg[1][EN_BIT] && st_q.cfg[1][CS_MSB:CS_LSB] == SRC_ALT)
      |=> (bus1_bit_tick_o == $past(tmr5_ovf_i)))
    else $error("instance 1 source 01 not timer 5");

  disabled_quiet_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && !st_q.cfg[0][EN_BIT])
      |=> !(bus0_irq_o || bus0_bit_tick_o || tmr3_hi_reload_o))
    else $error("disabled instance active");

  long_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && st_q.cfg[0][EXT_BIT])
      |=> (bus0_hold_cycles_o == HOLD_EXT && bus0_setup_cycles_o == SETUP_EXT))
    else $error("extended timing not selected");

endmodule : smc_top

`default_nettype wire

// ### sim/smc_bus_partner.sv
/*
  Bus partner: a far-side master making START, data, STOP and an
  abandoned frame on one pair of lines.
  Assumes pull-ups, so released lines read high.
*/
`timescale 1ns/1ns
`default_nettype none

module smc_bus_partner (
  // Wire levels.
  output logic clock_line_o,
  output logic data_line_o
);
  // ----------
  // Frames
  // ----------
  // Both lines start released; the link clock stands still outside frames.
  initial begin
    clock_line_o = 1'b1;
    data_line_o = 1'b1;
  end

  // The odd offset keeps the link unrelated in phase to the system clock.
  task automatic start_frame();
    #37 data_line_o = 1'b0;
    #200 clock_line_o = 1'b0;
  endtask : start_frame

  // One bit per 400 ns link period, data changed while the clock is low.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #100 data_line_o = b[i];
      #100 clock_line_o = 1'b1;
      #200 clock_line_o = 1'b0;
    end
    #100 data_line_o = 1'b1;
  endtask : send_byte

  task automatic stop_frame();
    #100 data_line_o = 1'b0;
    #100 clock_line_o = 1'b1;
    #200 data_line_o = 1'b1;
  endtask : stop_frame

  // Data is let go before the clock, so the bus idles with no STOP seen.
  task automatic drop_frame();
    #100 data_line_o = 1'b1;
    #100 clock_line_o = 1'b1;
  endtask : drop_frame
endmodule : smc_bus_partner
`default_nettype wire

// ### sim/tb_top.sv
/*
  Self-checking bench for the serial bus configuration block.
  Assumes the package, design and partner files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top import smc_pkg::*; ;
  // ----------
  // Signals
  // ----------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] page = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [8:0] ev = 9'h000;
  logic [1:0] split = 2'b00;
  logic sel = 1'b0;
  logic rd_seen = 1'b0;
  logic [3:0] snap_kind = 4'h0;
  logic [7:0] c0 = 8'h00;
  logic [7:0] c1 = 8'h00;
  logic [19:0] notes[$];
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  wire p_scl;
  wire p_sda;
  wire [7:0] rdata;
  wire [3:0] pul;
  wire [9:0] lvl;
  wire [15:0] cyc;

  initial begin
    forever #25 clk = ~clk;
  end

  // The bus not in use idles high, as its pull-ups would leave it.
  smc_top i_smc_top (
    .clock_i(clk), .rst_i(rst), .ce_i(ce), .sfr_addr_i(addr), .sfr_page_i(page),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .bus0_clock_line_i(sel | p_scl), .bus0_data_line_i(sel | p_sda),
    .bus1_clock_line_i(!sel | p_scl), .bus1_data_line_i(!sel | p_sda),
    .tmr0_ovf_i(ev[0]), .tmr1_ovf_i(ev[1]), .tmr2_hi_ovf_i(ev[2]),
    .tmr2_lo_ovf_i(ev[3]), .tmr5_ovf_i(ev[4]),
    .tmr3_split_i(split[0]), .tmr4_split_i(split[1]),
    .bus0_slave_event_i(ev[5]), .bus0_master_event_i(ev[6]),
    .bus1_slave_event_i(ev[7]), .bus1_master_event_i(ev[8]),
    .bus0_enable_o(lvl[0]), .bus1_enable_o(lvl[1]),
    .bus0_transfer_active_o(lvl[2]), .bus1_transfer_active_o(lvl[3]),
    .tmr3_lo_reload_o(lvl[4]), .tmr3_hi_reload_o(lvl[5]),
    .tmr4_lo_reload_o(lvl[6]), .tmr4_hi_reload_o(lvl[7]),
    .bus0_long_setup_hold_o(lvl[8]), .bus1_long_setup_hold_o(lvl[9]),
    .bus0_hold_cycles_o(cyc[3:0]), .bus0_setup_cycles_o(cyc[7:4]),
    .bus1_hold_cycles_o(cyc[11:8]), .bus1_setup_cycles_o(cyc[15:12]),
    .bus0_bit_tick_o(pul[0]), .bus1_bit_tick_o(pul[1]),
    .bus0_irq_o(pul[2]), .bus1_irq_o(pul[3])
  );

  smc_bus_partner i_smc_bus_partner (.clock_line_o(p_scl), .data_line_o(p_sda));

  // ----------
  // Expectations
  // ----------
  function automatic logic [15:0] lvl_exp(input logic b0, b1, s0, s1);
    logic h3;
    logic h4;
    h3 = c0[7] & c0[3] & s0;
    h4 = c1[7] & c1[3] & s1;
    return {6'h00, c1[4], c0[4], h4, h4 & ~split[1],
            h3, h3 & ~split[0], b1, b0, c1[7], c0[7]};
  endfunction : lvl_exp

  function automatic logic [15:0] cyc_exp();
    return {c1[4] ? SETUP_EXT : SETUP_LOW_TIME, c1[4] ? HOLD_EXT : HOLD_NORMAL,
            c0[4] ? SETUP_EXT : SETUP_LOW_TIME, c0[4] ? HOLD_EXT : HOLD_NORMAL};
  endfunction : cyc_exp

  // Bus 1 takes timer 5 in place of timer 1 for code 01.
  function automatic logic [3:0] pul_exp(input logic [8:0] e);
    logic s1;
    s1 = (c1[1:0] == 2'b01) ? e[4] : e[c1[1:0]];
    return {c1[7] & (e[8] | e[7] & ~c1[6]), c0[7] & (e[6] | e[5] & ~c0[6]),
            c1[7] & s1, c0[7] & e[c0[1:0]]};
  endfunction : pul_exp

  // ----------
  // Drivers and checking
  // ----------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic take(input logic [19:0] seen);
    check(seen, notes.size() > 0 ? notes.pop_front() : 20'hFFFFF);
  endtask : take

  // The model follows a write only if the edge took it with ce high.
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] pg,
                     input logic [7:0] d);
    if (!w) notes.push_back({4'h1, 8'h00, d});
    wr <= w;
    rd <= !w;
    addr <= a;
    page <= pg;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    if (w && ce && a == CFG_ADDR && pg == PAGE_BUS0) c0 = d & CFG_WR_MASK;
    if (w && ce && a == CFG_ADDR && pg == PAGE_BUS1) c1 = d & CFG_WR_MASK;
    @(posedge clk);
  endtask : acc

  task automatic snap(input logic [3:0] k, input logic [15:0] v);
    notes.push_back({k, v});
    snap_kind = k;
    @(posedge clk);
  endtask : snap

  task automatic fire(input logic [8:0] e);
    logic [3:0] p;
    p = pul_exp(e);
    if (p != 4'h0) notes.push_back({4'h2, 12'h000, p});
    ev <= e;
    @(posedge clk);
    ev <= 9'h000;
    repeat (2) @(posedge clk);
  endtask : fire

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Results are taken at the falling edge, once the rising edge settled.
  always @(posedge clk) rd_seen <= rd && ce;
  always @(negedge clk) begin
    if (rd_seen) take({4'h1, 8'h00, rdata});
    if (snap_kind == 4'h3) take({4'h3, 6'h00, lvl});
    if (snap_kind == 4'h4) take({4'h4, cyc});
    snap_kind = 4'h0;
    if (pul !== 4'h0) take({4'h2, 12'h000, pul});
  end

  // The whole run needs some 950 cycles; a hang is cut well beyond.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------
  // Tests
  // ----------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(35783));
    @(posedge clk);
    acc(1'b0, CFG_ADDR, PAGE_BUS0, CFG_RESET);
    acc(1'b0, CFG_ADDR, PAGE_BUS1, CFG_RESET);
    snap(4'h3, lvl_exp(1'b0, 1'b0, 1'b1, 1'b1));
    snap(4'h4, cyc_exp());
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      split <= 2'($urandom);
      acc(1'b1, CFG_ADDR, PAGE_BUS0, 8'($urandom));
      acc(1'b1, CFG_ADDR, PAGE_BUS1, 8'($urandom));
      acc(1'b1, CFG_ADDR, 4'h1, 8'($urandom));
      acc(1'b1, 8'hC2, PAGE_BUS0, 8'($urandom));
      acc(1'b0, CFG_ADDR, PAGE_BUS0, c0);
      acc(1'b0, CFG_ADDR, PAGE_BUS1, c1);
      acc(1'b0, 8'hC2, PAGE_BUS1, 8'h00);
      snap(4'h3, lvl_exp(1'b0, 1'b0, 1'b1, 1'b1));
      snap(4'h4, cyc_exp());
    end
    ce <= 1'b0;
    acc(1'b1, CFG_ADDR, PAGE_BUS0, ~c0);
    ce <= 1'b1;
    acc(1'b0, CFG_ADDR, PAGE_BUS0, c0);
    $display("register test done");
    for (int i = 0; i < 12; i++) begin
      acc(1'b1, CFG_ADDR, PAGE_BUS0, {i < 8 || $urandom, 5'($urandom), 2'(i)});
      acc(1'b1, CFG_ADDR, PAGE_BUS1, {i < 8 || $urandom, 5'($urandom), 2'(3 - i)});
      for (int k = 0; k < 9; k++) fire(9'h001 << k);
    end
    $display("event test done");
    for (int b = 0; b < 2; b++) begin
      sel <= 1'(b);
      // A fixed split per instance makes sure the split reload case is reached.
      split <= 2'(b + 1);
      acc(1'b1, CFG_ADDR, b ? PAGE_BUS0 : PAGE_BUS1, 8'h00);
      acc(1'b1, CFG_ADDR, b ? PAGE_BUS1 : PAGE_BUS0, 8'h8C);
      i_smc_bus_partner.start_frame();
      settle();
      snap(4'h3, lvl_exp(b == 0, b == 1, b == 1, b == 0));
      acc(1'b0, CFG_ADDR, b ? PAGE_BUS1 : PAGE_BUS0, 8'hAC);
      i_smc_bus_partner.send_byte(8'($urandom));
      i_smc_bus_partner.stop_frame();
      settle();
      snap(4'h3, lvl_exp(1'b0, 1'b0, 1'b1, 1'b1));
      acc(1'b0, CFG_ADDR, b ? PAGE_BUS1 : PAGE_BUS0, 8'h8C);
      i_smc_bus_partner.start_frame();
      i_smc_bus_partner.drop_frame();
      settle();
      repeat (FREE_PERIODS) fire(9'h001);
      snap(4'h3, lvl_exp(b == 0, b == 1, 1'b1, 1'b1));
      fire(9'h001);
      settle();
      snap(4'h3, lvl_exp(1'b0, 1'b0, 1'b1, 1'b1));
      // A frame stuck with its clock low trips the timeout timer; its handler
      // resets the instance by clearing and setting the enable bit.
      i_smc_bus_partner.start_frame();
      settle();
      acc(1'b1, CFG_ADDR, b ? PAGE_BUS1 : PAGE_BUS0, 8'h0C);
      acc(1'b1, CFG_ADDR, b ? PAGE_BUS1 : PAGE_BUS0, 8'h8C);
      acc(1'b0, CFG_ADDR, b ? PAGE_BUS1 : PAGE_BUS0, 8'h8C);
      i_smc_bus_partner.drop_frame();
      settle();
      snap(4'h3, lvl_exp(1'b0, 1'b0, 1'b1, 1'b1));
    end
    $display("busy test done");
    settle();
    check(20'(notes.size()), 20'h00000);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
